// file: test/i2c_status_flag_logic_bench.sv
/*
 * Bench for the two-wire status flags: bus partner model, APB master tasks, one task per scenario.
 * Assumes i2csf_pkg and the flag block are compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none

// Other master or slave on the bus: drives clock and data lines, 160 ns link period
module i2csf_partner (
    input wire logic pclk,
    output var logic scl,
    output var logic sda
);
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end

    // Half a link period
    task automatic half_period;
        repeat (4) @(posedge pclk);
    endtask : half_period

    // Data falls while clock high, then clock low
    task automatic send_start;
        scl <= 1'b1;
        sda <= 1'b1;
        half_period();
        sda <= 1'b0;
        half_period();
        scl <= 1'b0;
        half_period();
    endtask : send_start

    // Data set while clock low, one clock pulse
    task automatic send_bit(input logic b);
        sda <= b;
        half_period();
        scl <= 1'b1;
        half_period();
        scl <= 1'b0;
    endtask : send_bit

    // Eight bits, most significant first
    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            send_bit(b[i]);
        end
    endtask : send_byte

    // Data rises while clock high; lines left idle high
    task automatic send_stop;
        sda <= 1'b0;
        half_period();
        scl <= 1'b1;
        half_period();
        sda <= 1'b1;
        half_period();
    endtask : send_stop

    // Clock low with data high, ready for bit traffic
    task automatic park_low;
        scl <= 1'b0;
        half_period();
    endtask : park_low
endmodule : i2csf_partner

module i2c_status_flag_logic_bench;
    localparam logic [31:0] MATCH_WORD = 32'h1 << i2csf_pkg::BIT_MATCH;
    localparam logic [31:0] ARB_WORD = 32'h1 << i2csf_pkg::BIT_ARB;

    logic pclk = 1'b0;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic scl_pin;
    logic sda_pin;
    logic sda_drive;
    int n_mismatch = 0;
    int total_checks = 0;

    // 50 MHz system clock
    always #10 pclk = ~pclk;

    i2csf_flags i2csf_flags_i (
        .pclk (pclk),
        .presetn (presetn),
        .psel (psel),
        .penable (penable),
        .pwrite (pwrite),
        .paddr (paddr),
        .pwdata (pwdata),
        .prdata (prdata),
        .pready (pready),
        .pslverr (pslverr),
        .scl_pin (scl_pin),
        .sda_pin (sda_pin),
        .sda_drive (sda_drive)
    );

    i2csf_partner i2csf_partner_i (
        .pclk (pclk),
        .scl (scl_pin),
        .sda (sda_pin)
    );

    // Counts, verdict and end of run
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict

    // One comparison
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // Bounded wait for ready in the access phase
    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            n_mismatch++;
            $display("wrong value pready expected 1 seen %b", pready);
            give_verdict();
        end
    endtask : wait_ready

    // APB write: setup, access held until ready
    task automatic apb_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= 1'b1;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        wait_ready();
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb_write

    // APB read: data taken at the ready edge
    task automatic apb_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= a;
        @(posedge pclk);
        penable <= 1'b1;
        wait_ready();
        d = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb_read

    // Read a register and compare
    task automatic expect_reg(input string name, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        apb_read(a, d);
        check(name, exp, d);
    endtask : expect_reg

    // Values after reset
    task automatic t_reset_values;
        expect_reg("status after reset", i2csf_pkg::ADDR_STATUS, 32'h0);
        expect_reg("own address after reset", i2csf_pkg::ADDR_OWN, {24'h0, i2csf_pkg::OWN_RESET});
    endtask : t_reset_values

    // Own address match and the read-then-zero clear
    task automatic t_own_match;
        apb_write(i2csf_pkg::ADDR_CTRL, 32'h0);
        apb_write(i2csf_pkg::ADDR_OWN, 32'h54);
        i2csf_partner_i.send_start();
        i2csf_partner_i.send_byte(8'h55);
        i2csf_partner_i.send_stop();
        apb_write(i2csf_pkg::ADDR_STATUS, 32'h0);
        expect_reg("match after unread zero write", i2csf_pkg::ADDR_STATUS, MATCH_WORD);
        apb_write(i2csf_pkg::ADDR_STATUS, MATCH_WORD);
        expect_reg("match after one write", i2csf_pkg::ADDR_STATUS, MATCH_WORD);
        apb_write(i2csf_pkg::ADDR_STATUS, 32'h0);
        expect_reg("match after read and zero write", i2csf_pkg::ADDR_STATUS, 32'h0);
    endtask : t_own_match

    // Foreign address ignored; own address sent with direction bit 0 matches
    task automatic t_addr_compare;
        i2csf_partner_i.send_start();
        i2csf_partner_i.send_byte(8'hab);
        i2csf_partner_i.send_stop();
        expect_reg("match after foreign address", i2csf_pkg::ADDR_STATUS, 32'h0);
        i2csf_partner_i.send_start();
        i2csf_partner_i.send_byte(8'h54);
        i2csf_partner_i.send_stop();
        expect_reg("match with direction bit 0", i2csf_pkg::ADDR_STATUS, MATCH_WORD);
        apb_write(i2csf_pkg::ADDR_STATUS, 32'h0);
        expect_reg("match cleared after compare", i2csf_pkg::ADDR_STATUS, 32'h0);
    endtask : t_addr_compare

    // General call address
    task automatic t_general_call;
        i2csf_partner_i.send_start();
        i2csf_partner_i.send_byte({i2csf_pkg::GEN_CALL, 1'b0});
        i2csf_partner_i.send_stop();
        expect_reg("match after general call", i2csf_pkg::ADDR_STATUS, MATCH_WORD);
        apb_write(i2csf_pkg::ADDR_STATUS, 32'h0);
        expect_reg("match cleared after general call", i2csf_pkg::ADDR_STATUS, 32'h0);
    endtask : t_general_call

    // Master transmit line disagreement
    task automatic t_line_loss;
        apb_write(i2csf_pkg::ADDR_CTRL, 32'h3);
        sda_drive <= 1'b1;
        i2csf_partner_i.send_start();
        i2csf_partner_i.send_bit(1'b1);
        expect_reg("arbitration with lines agreeing", i2csf_pkg::ADDR_STATUS, 32'h0);
        i2csf_partner_i.send_bit(1'b0);
        expect_reg("arbitration with lines differing", i2csf_pkg::ADDR_STATUS, ARB_WORD);
        apb_write(i2csf_pkg::ADDR_CTRL, 32'h0);
        i2csf_partner_i.send_stop();
        apb_write(i2csf_pkg::ADDR_STATUS, 32'h0);
        expect_reg("arbitration cleared", i2csf_pkg::ADDR_STATUS, 32'h0);
    endtask : t_line_loss

    // Synchronous format overrun
    task automatic t_overrun;
        apb_write(i2csf_pkg::ADDR_RXFULL, 32'h0);
        apb_write(i2csf_pkg::ADDR_OWN, 32'h55);
        i2csf_partner_i.park_low();
        i2csf_partner_i.send_byte(8'h3c);
        expect_reg("overrun with buffer empty", i2csf_pkg::ADDR_STATUS, 32'h0);
        apb_write(i2csf_pkg::ADDR_RXFULL, 32'h1);
        i2csf_partner_i.send_byte(8'hc3);
        expect_reg("overrun with buffer full", i2csf_pkg::ADDR_STATUS, ARB_WORD);
        apb_write(i2csf_pkg::ADDR_STATUS, 32'h0);
        expect_reg("overrun cleared", i2csf_pkg::ADDR_STATUS, 32'h0);
        apb_write(i2csf_pkg::ADDR_RXFULL, 32'h0);
        apb_write(i2csf_pkg::ADDR_OWN, 32'h54);
        i2csf_partner_i.send_stop();
    endtask : t_overrun

    // Reset in mid-run with a flag set
    task automatic t_mid_reset;
        i2csf_partner_i.send_start();
        i2csf_partner_i.send_byte(8'h55);
        i2csf_partner_i.send_stop();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        expect_reg("status after mid-run reset", i2csf_pkg::ADDR_STATUS, 32'h0);
        expect_reg("own address after mid-run reset", i2csf_pkg::ADDR_OWN, {24'h0, i2csf_pkg::OWN_RESET});
    endtask : t_mid_reset

    // Overall limit on run length
    initial begin
        repeat (90000) @(posedge pclk);
        n_mismatch++;
        $display("wrong value run length expected under 90000 cycles seen limit");
        give_verdict();
    end

    // Reset, scenarios, verdict
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        sda_drive = 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        t_reset_values();
        t_own_match();
        t_addr_compare();
        t_general_call();
        t_line_loss();
        t_overrun();
        t_mid_reset();
        give_verdict();
    end
endmodule : i2c_status_flag_logic_bench
`default_nettype wire

// file: verilog/i2csf_link_if.sv
/*
 * Two-wire status flags: link-event interface, line sampler and the flag block with its APB registers.
 * Assumes every register runs on pclk, scl_pin and sda_pin are asynchronous pins,
 * and sda_drive comes from transmit logic on pclk.
 */
// The implementer's own choices: the APB register port and the placing of the registers.
// Overview of operation
// - Synchronous format: last bit received while rx_full_flag is 1 sets arb_lost_overrun_flag.
// - arb_lost_overrun_flag clears only on a write of 0 after reading it as 1.
// - Slave receive: first frame after start matching own_addr_bits sets addr_match_flag.
// - Slave receive: general call address as first frame after start sets addr_match_flag.
// - addr_match_flag clears on a write of 0 after a read returned it as 1.
// - addr_match_flag is status bit 1, read/write, reset value 0.
// - Master transmit: driven data level differing from sampled data at clock rise sets flag.
// - Address compare uses upper seven own_addr_reg bits against upper seven frame bits.
`timescale 1ns/1ps
`default_nettype none

// Link events handed from the sampler to the flag logic
interface i2csf_link_if;
    logic scl_rise;
    logic start_seen;
    logic sda_bit;
    // Producer and consumer views
    modport sampler (output scl_rise, output start_seen, output sda_bit);
    modport flags (input scl_rise, input start_seen, input sda_bit);
endinterface : i2csf_link_if

// Synchronises the two bus lines and decodes clock rise and start
module i2csf_line_sampler (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic scl_pin,
    input wire logic sda_pin,
    i2csf_link_if.sampler link
);
    logic scl_meta_ff;
    logic scl_sync_ff;
    logic scl_prev_ff;
    logic sda_meta_ff;
    logic sda_sync_ff;
    logic sda_prev_ff;
    logic nxt_scl_prev;
    logic nxt_sda_prev;

    // History stage follows the second synchroniser flop only
    always_comb begin
        nxt_scl_prev = scl_sync_ff;
        nxt_sda_prev = sda_sync_ff;
    end

    // Two-flop synchronisers; idle-high reset avoids a false edge after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_meta_ff <= 1'b1;
            scl_sync_ff <= 1'b1;
            scl_prev_ff <= 1'b1;
            sda_meta_ff <= 1'b1;
            sda_sync_ff <= 1'b1;
            sda_prev_ff <= 1'b1;
        end else begin
            scl_meta_ff <= scl_pin;
            scl_sync_ff <= scl_meta_ff;
            scl_prev_ff <= nxt_scl_prev;
            sda_meta_ff <= sda_pin;
            sda_sync_ff <= sda_meta_ff;
            sda_prev_ff <= nxt_sda_prev;
        end
    end

    // Clock rise, start (data falls while clock high) and sampled data level
    assign link.scl_rise = scl_sync_ff & ~scl_prev_ff;
    assign link.start_seen = scl_sync_ff & scl_prev_ff & sda_prev_ff & ~sda_sync_ff;
    assign link.sda_bit = sda_sync_ff;

    // A clock rise lasts exactly one pclk cycle
    a_rise_single_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        link.scl_rise |=> !link.scl_rise)
        else $error("clock rise event lasted more than one cycle");
endmodule : i2csf_line_sampler

// Status flags with APB access to status, own address, control and receive-full registers
module i2csf_flags #(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 32,
    parameter int FRAME_BITS = i2csf_pkg::FRAME_BITS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output var logic [DATA_W-1:0] prdata,
    output var logic pready,
    output var logic pslverr,
    input wire logic scl_pin,
    input wire logic sda_pin,
    input wire logic sda_drive
);
    localparam int CNT_W = $clog2(FRAME_BITS) + 1;

    typedef enum logic [2:0] {
        I2CSF_ST_IDLE = 3'b001,
        I2CSF_ST_ADDR = 3'b010,
        I2CSF_ST_DONE = 3'b100
    } i2csf_frame_e;

    i2csf_link_if link_bus ();

    i2csf_frame_e state_ff;
    i2csf_frame_e nxt_state;
    logic [CNT_W-1:0] bit_cnt_ff;
    logic [CNT_W-1:0] nxt_bit_cnt;
    logic [FRAME_BITS-1:0] frame_ff;
    logic [FRAME_BITS-1:0] nxt_frame;
    logic [7:0] own_addr_reg_ff;
    logic [7:0] nxt_own_addr_reg;
    logic [1:0] ctrl_ff;
    logic [1:0] nxt_ctrl;
    logic rx_full_flag_ff;
    logic nxt_rx_full_flag;
    logic arb_lost_overrun_flag_ff;
    logic nxt_arb_lost_overrun_flag;
    logic addr_match_flag_ff;
    logic nxt_addr_match_flag;
    logic arb_read_ff;
    logic nxt_arb_read;
    logic match_read_ff;
    logic nxt_match_read;
    logic [DATA_W-1:0] prdata_ff;
    logic [DATA_W-1:0] nxt_prdata;
    logic pready_ff;
    logic nxt_pready;
    logic pslverr_ff;
    logic nxt_pslverr;

    logic setup_phase;
    logic wr_access;
    logic rd_access;
    logic wr_status;
    logic rd_status;
    logic wr_own;
    logic wr_ctrl;
    logic wr_rxfull;
    logic fmt_sync;
    logic slave_rx;
    logic master_tx;
    logic last_sync_bit;
    logic frame_done;
    logic own_hit;
    logic gen_hit;
    logic overrun_hit;
    logic line_loss;
    logic arb_set;
    logic arb_clear;
    logic match_set;
    logic match_clear;
    logic [6:0] own_addr_bits;
    logic [6:0] frame_addr;
    logic [DATA_W-1:0] status_word;

    // Pin sampling and edge decode
    i2csf_line_sampler i2csf_line_sampler_i (
        .pclk (pclk),
        .presetn (presetn),
        .scl_pin (scl_pin),
        .sda_pin (sda_pin),
        .link (link_bus)
    );

    // APB phase and register decode; writes land only at the access edge
    assign setup_phase = psel & ~penable;
    assign wr_access = psel & penable & pready_ff & pwrite;
    assign rd_access = psel & penable & pready_ff & ~pwrite;
    assign wr_status = wr_access & (paddr == i2csf_pkg::ADDR_STATUS);
    assign rd_status = rd_access & (paddr == i2csf_pkg::ADDR_STATUS);
    assign wr_own = wr_access & (paddr == i2csf_pkg::ADDR_OWN);
    assign wr_ctrl = wr_access & (paddr == i2csf_pkg::ADDR_CTRL);
    assign wr_rxfull = wr_access & (paddr == i2csf_pkg::ADDR_RXFULL);

    // Mode decode from format select and control bits
    assign fmt_sync = own_addr_reg_ff[i2csf_pkg::BIT_FMT];
    assign slave_rx = ({ctrl_ff[i2csf_pkg::BIT_MST], ctrl_ff[i2csf_pkg::BIT_TRS]} == i2csf_pkg::MODE_SLV_RX);
    assign master_tx = ({ctrl_ff[i2csf_pkg::BIT_MST], ctrl_ff[i2csf_pkg::BIT_TRS]} == i2csf_pkg::MODE_MST_TX);

    // Upper seven bits on both sides of the compare
    assign own_addr_bits = own_addr_reg_ff[7:1];
    assign frame_addr = frame_ff[FRAME_BITS-2 -: 7];

    // Frame end events: first frame after start, or each byte in synchronous format
    assign frame_done = !fmt_sync && (state_ff == I2CSF_ST_ADDR) && link_bus.scl_rise
        && (bit_cnt_ff == CNT_W'(FRAME_BITS - 1));
    assign last_sync_bit = fmt_sync && link_bus.scl_rise && (bit_cnt_ff == CNT_W'(FRAME_BITS - 1));

    // Set and clear terms of both flags
    assign own_hit = (frame_addr == own_addr_bits);
    assign gen_hit = (frame_addr == i2csf_pkg::GEN_CALL);
    assign match_set = frame_done & slave_rx & (own_hit | gen_hit);
    assign overrun_hit = last_sync_bit & rx_full_flag_ff;
    assign line_loss = master_tx & link_bus.scl_rise & (sda_drive != link_bus.sda_bit);
    assign arb_set = overrun_hit | line_loss;
    assign arb_clear = wr_status & ~pwdata[i2csf_pkg::BIT_ARB] & arb_read_ff;
    assign match_clear = wr_status & ~pwdata[i2csf_pkg::BIT_MATCH] & match_read_ff;

    // Frame tracker: on each clock rise of the first frame, or any in synchronous format, shift data and count bits
    always_comb begin
        nxt_state = state_ff;
        nxt_bit_cnt = bit_cnt_ff;
        nxt_frame = frame_ff;
        if (wr_own) begin
            nxt_state = I2CSF_ST_IDLE;
            nxt_bit_cnt = '0;
        end else if (fmt_sync) begin
            if (link_bus.scl_rise) begin
                nxt_frame = {frame_ff[FRAME_BITS-2:0], link_bus.sda_bit};
                nxt_bit_cnt = last_sync_bit ? '0 : bit_cnt_ff + CNT_W'(1);
            end
        end else begin
            unique case (state_ff)
                I2CSF_ST_IDLE: begin
                    if (link_bus.start_seen) begin
                        nxt_state = I2CSF_ST_ADDR;
                        nxt_bit_cnt = '0;
                    end
                end
                I2CSF_ST_ADDR: begin
                    if (link_bus.start_seen) begin
                        nxt_bit_cnt = '0;
                    end else if (link_bus.scl_rise) begin
                        nxt_frame = {frame_ff[FRAME_BITS-2:0], link_bus.sda_bit};
                        if (frame_done) begin
                            nxt_state = I2CSF_ST_DONE;
                            nxt_bit_cnt = '0;
                        end else begin
                            nxt_bit_cnt = bit_cnt_ff + CNT_W'(1);
                        end
                    end
                end
                I2CSF_ST_DONE: begin
                    if (link_bus.start_seen) begin
                        nxt_state = I2CSF_ST_ADDR;
                        nxt_bit_cnt = '0;
                    end
                end
            endcase
        end
    end

    // Software registers
    always_comb begin
        nxt_own_addr_reg = own_addr_reg_ff;
        nxt_ctrl = ctrl_ff;
        nxt_rx_full_flag = rx_full_flag_ff;
        if (wr_own) begin
            nxt_own_addr_reg = pwdata[7:0];
        end
        if (wr_ctrl) begin
            nxt_ctrl = pwdata[1:0];
        end
        if (wr_rxfull) begin
            nxt_rx_full_flag = pwdata[i2csf_pkg::BIT_RXF];
        end
    end

    // Flags: hardware set wins over a software clear in the same cycle
    always_comb begin
        nxt_arb_lost_overrun_flag = arb_set | (arb_lost_overrun_flag_ff & ~arb_clear);
        nxt_addr_match_flag = match_set | (addr_match_flag_ff & ~match_clear);
        nxt_arb_read = arb_read_ff;
        nxt_match_read = match_read_ff;
        if (wr_status) begin
            nxt_arb_read = 1'b0;
            nxt_match_read = 1'b0;
        end
        if (rd_status) begin
            nxt_arb_read = prdata_ff[i2csf_pkg::BIT_ARB];
            nxt_match_read = prdata_ff[i2csf_pkg::BIT_MATCH];
        end
    end

    // Status word layout
    always_comb begin
        status_word = '0;
        status_word[i2csf_pkg::BIT_ARB] = arb_lost_overrun_flag_ff;
        status_word[i2csf_pkg::BIT_MATCH] = addr_match_flag_ff;
    end

    // APB answer: ready one cycle after setup, read data captured at setup
    always_comb begin
        nxt_pready = setup_phase;
        nxt_pslverr = 1'b0;
        nxt_prdata = prdata_ff;
        if (setup_phase && !pwrite) begin
            case (paddr)
                i2csf_pkg::ADDR_STATUS: begin
                    nxt_prdata = status_word;
                end
                i2csf_pkg::ADDR_OWN: begin
                    nxt_prdata = {{(DATA_W-8){1'b0}}, own_addr_reg_ff};
                end
                i2csf_pkg::ADDR_CTRL: begin
                    nxt_prdata = {{(DATA_W-2){1'b0}}, ctrl_ff};
                end
                i2csf_pkg::ADDR_RXFULL: begin
                    nxt_prdata = {{(DATA_W-1){1'b0}}, rx_full_flag_ff};
                end
                default: begin
                    nxt_prdata = '0;
                end
            endcase
        end
    end

    // State registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= I2CSF_ST_IDLE;
            bit_cnt_ff <= '0;
            frame_ff <= '0;
            own_addr_reg_ff <= i2csf_pkg::OWN_RESET;
            ctrl_ff <= 2'h0;
            rx_full_flag_ff <= 1'b0;
            arb_lost_overrun_flag_ff <= 1'b0;
            addr_match_flag_ff <= 1'b0;
            arb_read_ff <= 1'b0;
            match_read_ff <= 1'b0;
            prdata_ff <= '0;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            bit_cnt_ff <= nxt_bit_cnt;
            frame_ff <= nxt_frame;
            own_addr_reg_ff <= nxt_own_addr_reg;
            ctrl_ff <= nxt_ctrl;
            rx_full_flag_ff <= nxt_rx_full_flag;
            arb_lost_overrun_flag_ff <= nxt_arb_lost_overrun_flag;
            addr_match_flag_ff <= nxt_addr_match_flag;
            arb_read_ff <= nxt_arb_read;
            match_read_ff <= nxt_match_read;
            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
        end
    end

    // Outputs straight from flops
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;

    // Overrun on last synchronous bit with receive buffer full
    a_overrun_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
        overrun_hit |=> arb_lost_overrun_flag_ff)
        else $error("overrun did not set the arbitration/overrun flag");

    // Arbitration/overrun flag falls only after read-as-one then write-zero
    a_arb_clear_gate: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(arb_lost_overrun_flag_ff) |-> $past(wr_status) && $past(arb_read_ff)
            && !$past(pwdata[i2csf_pkg::BIT_ARB]))
        else $error("arbitration/overrun flag cleared without read and zero write");

    // Own address match in slave receive
    a_own_addr_match: assert property (@(posedge pclk) disable iff (!presetn)
        frame_done && slave_rx && (frame_ff[FRAME_BITS-2 -: 7] == own_addr_reg_ff[7:1]) |=> addr_match_flag_ff)
        else $error("own address frame did not set the match flag");

    // General call in slave receive
    a_general_call_match: assert property (@(posedge pclk) disable iff (!presetn)
        frame_done && slave_rx && (frame_ff[FRAME_BITS-2 -: 7] == i2csf_pkg::GEN_CALL) |=> addr_match_flag_ff)
        else $error("general call frame did not set the match flag");

    // Match flag falls only after read-as-one then write-zero
    a_match_clear_gate: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(addr_match_flag_ff) |-> $past(wr_status) && $past(match_read_ff)
            && !$past(pwdata[i2csf_pkg::BIT_MATCH]))
        else $error("match flag cleared without read and zero write");

    // Line disagreement in master transmit
    a_line_loss_sets: assert property (@(posedge pclk) disable iff (!presetn)
        line_loss |=> arb_lost_overrun_flag_ff)
        else $error("data line disagreement did not set the arbitration flag");

    // Ready stands for one cycle per transfer
    a_ready_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
        pready_ff |=> !pready_ff)
        else $error("ready stood longer than one cycle");
endmodule : i2csf_flags
`default_nettype wire

// file: verilog/i2csf_pkg.sv
/*
 * Constants shared by the two-wire status-flag block: register offsets, bit positions, reset values, encodings.
 * Assumes a 32-bit APB bus, word-aligned registers.
 */
package i2csf_pkg;
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_OWN = 8'h04;
    localparam logic [7:0] ADDR_CTRL = 8'h08;
    localparam logic [7:0] ADDR_RXFULL = 8'h0c;
    localparam int BIT_MATCH = 1;
    localparam int BIT_ARB = 2;
    localparam int BIT_FMT = 0;
    localparam int BIT_MST = 0;
    localparam int BIT_TRS = 1;
    localparam int BIT_RXF = 0;
    localparam logic [7:0] OWN_RESET = 8'h00;
    localparam logic [6:0] GEN_CALL = 7'h00;
    localparam int FRAME_BITS = 8;
    localparam logic [1:0] MODE_SLV_RX = 2'h0;
    localparam logic [1:0] MODE_MST_TX = 2'h3;
endpackage : i2csf_pkg
